// >>> design/psc_config.sv
// psc_config: SMBus slave holding the synthesizer configuration bytes and decoding the controls
`timescale 1ns/1ps
module psc_config import psc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h55,   // slave address, arbitrary
    parameter logic [3:0] VENDOR_ID = 4'hA,   // identity value, arbitrary
    parameter logic [3:0] REVISION = 4'h3     // identity value, arbitrary
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // SMBus pins, data is open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOutEnN,
    // control pins
    input wire logic controlPinZero,
    input wire logic controlPinOne,
    // PLL settings
    output logic [8:0] refDiv1,
    output logic [8:0] refDiv2,
    output logic [8:0] refDiv3,
    output logic [11:0] fbDiv1,
    output logic [11:0] fbDiv2,
    output logic [11:0] fbDiv3,
    output logic [2:0] pllBypass,
    output logic [2:0] vcoRange,
    // channel source selects, channel k at [3k+2:3k]
    output logic [17:0] chanSource,
    // power and output state
    output logic pllPowerDown,
    output logic inputStagePowerDown,
    output logic outputsHiZ,
    output logic outputsForcedLow,
    output logic dividerBypass,
    output logic inputSelect,
    output logic [1:0] inputSource,
    output logic spreadPowerDown
);

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,   // bus free
        ST_RECV = 6'b000010,   // shifting a byte in
        ST_ACK = 6'b000100,    // ack slot we own, or gap before sending
        ST_SEND = 6'b001000,   // shifting a byte out
        ST_MACK = 6'b010000,   // master ack slot after a sent byte
        ST_WAIT = 6'b100000    // not addressed or nack, wait for stop
    } psc_state_e;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // configuration bytes
    logic [7:0] cfg [1:LAST];
    // bus bookkeeping
    psc_state_e state;
    logic sclPrev;           // last sampled clock pin
    logic sdaPrev;           // last sampled data pin
    logic [7:0] shiftReg;    // shared rx/tx shifter
    logic [3:0] bitCnt;      // bits shifted in current byte
    logic [1:0] byteIdx;     // 0 address, 1 command, 2 first data, 3 later
    logic readMode;          // address byte had the read bit
    logic blockMode;         // command top bit selects block transfer
    logic cntPending;        // block read still owes its count byte
    logic [6:0] ptr;         // register pointer, auto-increments

    // bus events; pins are treated as synchronous to clock
    wire sclRise = sclIn & ~sclPrev;
    wire sclFall = ~sclIn & sclPrev;
    wire busStart = sclIn & sclPrev & sdaPrev & ~sdaIn;
    wire busStop = sclIn & sclPrev & ~sdaPrev & sdaIn;
    wire byteDone = (state == ST_RECV) & sclFall & (bitCnt == 4'h8);
    wire addrHit = (shiftReg[7:1] == DEV_ADDR);
    wire ptrValid = (ptr != IDX_ID) & (ptr <= IDX_LAST);

    // write strobe: data bytes of a write, skipping the block count byte
    wire cfgWrEn = byteDone & (byteIdx[1]) & ~readMode
                   & ~(blockMode & (byteIdx == 2'h2)) & ptrValid;

    // transmit byte: identity only in a byte read, zero in block or unmapped
    wire [7:0] idByte = blockMode ? 8'h00 : {REVISION, VENDOR_ID};
    wire [7:0] regByte = (ptr == IDX_ID) ? idByte :
                         (ptr <= IDX_LAST) ? cfg[ptr[4:0]] : 8'h00;
    wire [7:0] txByte = cntPending ? {1'b0, cfg[IDX_LAST[4:0]][6:0]} : regByte;

    // bus sequencer; no clock stretching, so host timing must allow a few cycles per edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            shiftReg <= 8'h00;
            bitCnt <= 4'h0;
            byteIdx <= 2'h0;
            readMode <= 1'b0;
            blockMode <= 1'b0;
            cntPending <= 1'b0;
            ptr <= 7'h00;
            sdaOut <= 1'b0;
            sdaOutEnN <= 1'b1;
        end else begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
            sdaOut <= 1'b0;   // open drain: only ever pulls low
            if (busStart) begin
                // start or repeated start keeps pointer and block flag
                state <= ST_RECV;
                bitCnt <= 4'h0;
                byteIdx <= 2'h0;
                sdaOutEnN <= 1'b1;
            end else if (busStop) begin
                state <= ST_IDLE;
                sdaOutEnN <= 1'b1;
            end else begin
                case (state)
                    ST_RECV: begin
                        if (sclRise && bitCnt != 4'h8) begin
                            shiftReg <= {shiftReg[6:0], sdaIn};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (byteDone) begin
                            if (byteIdx != 2'h3) begin
                                byteIdx <= byteIdx + 2'h1;
                            end
                            if (byteIdx == 2'h0) begin
                                // address byte: ack only our own address
                                readMode <= shiftReg[0];
                                cntPending <= shiftReg[0] & blockMode;
                                state <= addrHit ? ST_ACK : ST_WAIT;
                                sdaOutEnN <= ~addrHit;
                            end else if (byteIdx == 2'h1) begin
                                // command byte loads pointer and transfer kind
                                blockMode <= shiftReg[7];
                                ptr <= shiftReg[6:0];
                                state <= ST_ACK;
                                sdaOutEnN <= 1'b0;
                            end else begin
                                // data byte; pointer steps past the block count
                                if (!(blockMode && byteIdx == 2'h2) && ptr != 7'h7F) begin
                                    ptr <= ptr + 7'h01;
                                end
                                state <= ST_ACK;
                                sdaOutEnN <= 1'b0;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (readMode) begin
                                // present first bit right away
                                shiftReg <= txByte;
                                sdaOutEnN <= txByte[7];
                                cntPending <= 1'b0;
                                if (!cntPending && ptr != 7'h7F) begin
                                    ptr <= ptr + 7'h01;
                                end
                                state <= ST_SEND;
                            end else begin
                                sdaOutEnN <= 1'b1;
                                state <= ST_RECV;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (sclFall) begin
                            bitCnt <= bitCnt + 4'h1;
                            shiftReg <= {shiftReg[6:0], 1'b0};
                            if (bitCnt == 4'h7) begin
                                sdaOutEnN <= 1'b1;   // release for master ack
                                state <= ST_MACK;
                            end else begin
                                sdaOutEnN <= shiftReg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        // nack ends the read; ack waits for the fall to send on
                        if (sclRise) begin
                            state <= sdaIn ? ST_WAIT : ST_ACK;
                        end
                    end
                    default: begin
                        sdaOutEnN <= 1'b1;   // idle and wait ignore the bus
                    end
                endcase
            end
        end
    end

    // configuration store; reset returns factory defaults
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg <= CFG_DEFAULT;
        end else if (cfgWrEn) begin
            cfg[ptr[4:0]] <= shiftReg;
        end
    end

    a_write_lands: assert property (cfgWrEn |=> cfg[$past(ptr[4:0])] == $past(shiftReg))
        else $error("written byte did not land in its register");
    a_id_value: assert property (
        (state == ST_ACK && sclFall && readMode && !cntPending && !blockMode && ptr == IDX_ID)
        |=> shiftReg == {REVISION, VENDOR_ID})
        else $error("identity byte read returned a wrong value");
    a_block_no_id: assert property (
        (state == ST_ACK && sclFall && readMode && !cntPending && blockMode && ptr == IDX_ID)
        |=> shiftReg == 8'h00)
        else $error("identity byte leaked into a block read");

    // zero ratios are illegal; hold them at one so the dividers never stall
    function automatic logic [11:0] legalRatio(input logic [11:0] raw);
        legalRatio = (raw == 12'h000) ? 12'h001 : raw;
    endfunction

    // field decode from the byte map
    wire [1:0] pin0Func = cfg[IDX_CTRL[4:0]][1:0];
    wire [1:0] pin1Func = cfg[IDX_CTRL[4:0]][3:2];
    wire clkSelBit = cfg[IDX_CTRL[4:0]][POS_CLKSEL];
    wire [1:0] inSrc = cfg[IDX_IN_SRC[4:0]][7:6];
    wire pdBit = cfg[IDX_PWR[4:0]][POS_PD];
    wire [2:0] sscMode = cfg[IDX_SSC[4:0]][POS_SSC+2:POS_SSC];
    wire pin0Low = ~controlPinZero;
    wire pin1Low = ~controlPinOne;

    // ratios pass straight to the analog dividers, fout = fin*fb/(ref*post)
    wire [11:0] next_refDiv1 = legalRatio({4'h0, cfg[IDX_REF1_LO[4:0]]});
    wire [11:0] next_refDiv2 = legalRatio({3'h0, cfg[IDX_VCO_RANGE[4:0]][0],
                                           cfg[IDX_REF2_LO[4:0]]});
    wire [11:0] next_refDiv3 = legalRatio({3'h0, cfg[IDX_CH0_SRC[4:0]][0],
                                           cfg[IDX_REF3_LO[4:0]]});
    wire [11:0] next_fbDiv1 = legalRatio({cfg[IDX_PLL_BYPASS[4:0]][3:0],
                                          cfg[IDX_FB1_LO[4:0]]});
    wire [11:0] next_fbDiv2 = legalRatio({cfg[IDX_VCO_RANGE[4:0]][POS_NHI+3:POS_NHI],
                                          cfg[IDX_FB2_LO[4:0]]});
    wire [11:0] next_fbDiv3 = legalRatio({cfg[IDX_CH0_SRC[4:0]][POS_NHI+3:POS_NHI],
                                          cfg[IDX_FB3_LO[4:0]]});
    // source selects, codes passed as stored, reserved ones included
    wire [17:0] next_chanSource = {cfg[IDX_PWR[4:0]][POS_SRC_HI:POS_SRC_MID],
                                   cfg[IDX_PWR[4:0]][POS_SRC_MID-1:POS_SRC_LO],
                                   cfg[IDX_IN_SRC[4:0]][POS_SRC_HI:POS_SRC_MID],
                                   cfg[IDX_IN_SRC[4:0]][POS_SRC_MID-1:POS_SRC_LO],
                                   cfg[IDX_CTRL[4:0]][7:POS_SRC_HI],
                                   cfg[IDX_CH0_SRC[4:0]][7:POS_SRC_HI]};
    // power control: register bit or pin zero in power-down function
    wire next_powerDown = pdBit | ((pin0Func == FN0_POWER_DOWN) & pin0Low);
    wire next_testBypass = (pin0Func == FN0_TEST_BYPASS) & pin0Low & ~next_powerDown;
    // pin one states lose against any power-down
    wire next_hiZ = next_powerDown | ((pin1Func == FN1_HIGH_Z) & pin1Low);
    wire next_forcedLow = ~next_powerDown & (pin1Func == FN1_FORCE_LOW) & pin1Low;
    // pin input select only with two single-ended inputs
    wire pinSelects = (pin0Func == FN0_CLOCK_SELECT) & (inSrc == SRC_LVCMOS);
    wire next_inputSelect = pinSelects ? controlPinZero : clkSelBit;

    // decoded outputs are all registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refDiv1 <= 9'h000;
            refDiv2 <= 9'h000;
            refDiv3 <= 9'h000;
            fbDiv1 <= 12'h000;
            fbDiv2 <= 12'h000;
            fbDiv3 <= 12'h000;
            pllBypass <= 3'h0;
            vcoRange <= 3'h0;
            chanSource <= 18'h00000;
            pllPowerDown <= 1'b1;
            inputStagePowerDown <= 1'b1;
            outputsHiZ <= 1'b1;
            outputsForcedLow <= 1'b0;
            dividerBypass <= 1'b0;
            inputSelect <= 1'b0;
            inputSource <= 2'h0;
            spreadPowerDown <= 1'b1;
        end else begin
            refDiv1 <= next_refDiv1[8:0];
            refDiv2 <= next_refDiv2[8:0];
            refDiv3 <= next_refDiv3[8:0];
            fbDiv1 <= next_fbDiv1;
            fbDiv2 <= next_fbDiv2;
            fbDiv3 <= next_fbDiv3;
            pllBypass <= cfg[IDX_PLL_BYPASS[4:0]][7:5];
            vcoRange <= cfg[IDX_VCO_RANGE[4:0]][7:5];
            chanSource <= next_chanSource;
            pllPowerDown <= next_powerDown | next_testBypass;
            inputStagePowerDown <= next_powerDown;
            outputsHiZ <= next_hiZ;
            outputsForcedLow <= next_forcedLow;
            dividerBypass <= next_testBypass;
            inputSelect <= next_inputSelect;
            inputSource <= inSrc;
            spreadPowerDown <= (sscMode == SSC_BYPASS_CODE);
        end
    end

    a_pin_powerdown: assert property (
        (pin0Func == FN0_POWER_DOWN && !controlPinZero)
        |=> outputsHiZ && pllPowerDown && inputStagePowerDown && !dividerBypass)
        else $error("pin zero low did not power down");
    a_test_bypass: assert property (
        (pin0Func == FN0_TEST_BYPASS && !controlPinZero && !pdBit)
        |=> dividerBypass && pllPowerDown && !inputStagePowerDown)
        else $error("test bypass not entered");
    a_pin_clksel: assert property (
        (pin0Func == FN0_CLOCK_SELECT && inSrc == SRC_LVCMOS)
        |=> inputSelect == $past(controlPinZero))
        else $error("pin zero did not steer input select");
    a_clksel_ignored: assert property (
        (inSrc != SRC_LVCMOS) |=> inputSelect == $past(clkSelBit))
        else $error("pin zero steered input in crystal or differential mode");
    a_pd_over_low: assert property (
        $rose(inputStagePowerDown) |-> outputsHiZ && !outputsForcedLow)
        else $error("power-down did not win over pin one");
    a_spread_off: assert property (
        (sscMode == SSC_BYPASS_CODE) [*2] |-> spreadPowerDown)
        else $error("spreader not powered down in bypass");
    a_bypass_map: assert property (
        ##1 pllBypass == $past(cfg[IDX_PLL_BYPASS[4:0]][7:5]))
        else $error("VCO bypass bits not following byte three");

endmodule // psc_config

// >>> shared/psc_pkg.sv
// psc_pkg: register map, field positions and factory defaults of the synthesizer config logic
package psc_pkg;
    // register indices (SMBus command codes)
    localparam logic [6:0] IDX_ID = 7'h00;
    localparam logic [6:0] IDX_REF1_LO = 7'h01;
    localparam logic [6:0] IDX_FB1_LO = 7'h02;
    localparam logic [6:0] IDX_PLL_BYPASS = 7'h03;
    localparam logic [6:0] IDX_REF2_LO = 7'h04;
    localparam logic [6:0] IDX_FB2_LO = 7'h05;
    localparam logic [6:0] IDX_VCO_RANGE = 7'h06;
    localparam logic [6:0] IDX_REF3_LO = 7'h07;
    localparam logic [6:0] IDX_FB3_LO = 7'h08;
    localparam logic [6:0] IDX_CH0_SRC = 7'h09;
    localparam logic [6:0] IDX_CTRL = 7'h0A;
    localparam logic [6:0] IDX_IN_SRC = 7'h0B;
    localparam logic [6:0] IDX_PWR = 7'h0C;
    localparam logic [6:0] IDX_SSC = 7'h19;
    localparam logic [6:0] IDX_LAST = 7'h1A;
    localparam int LAST = 26;
    // field positions
    localparam int POS_SRC_HI = 5;
    localparam int POS_SRC_LO = 0;
    localparam int POS_SRC_MID = 3;
    localparam int POS_CLKSEL = 4;
    localparam int POS_PD = 6;
    localparam int POS_NHI = 1;
    localparam int POS_SSC = 4;
    // control pin function codes
    localparam logic [1:0] FN0_POWER_DOWN = 2'h0;
    localparam logic [1:0] FN0_TEST_BYPASS = 2'h1;
    localparam logic [1:0] FN0_CLOCK_SELECT = 2'h2;
    localparam logic [1:0] FN1_FORCE_LOW = 2'h0;
    localparam logic [1:0] FN1_HIGH_Z = 2'h1;
    localparam logic [1:0] SRC_LVCMOS = 2'h1;
    // spread modulation code treated as spread bypass
    localparam logic [2:0] SSC_BYPASS_CODE = 3'h0;
    // factory defaults, index 1..26; index 0 is the fixed identity byte
    localparam logic [7:0] CFG_DEFAULT [1:LAST] = '{
        8'h01, 8'h08, 8'h00,   // first: ref 1, fb 8, bypass off
        8'h1B, 8'hFA, 8'hE0,   // second: ref 27, fb 250, all VCOs high range
        8'h77, 8'h40, 8'h59,   // third: ref 375, fb 3136, ch0 from second
        8'h80, 8'h09, 8'h09,   // ch1 from third, ch2..ch5 from first
        8'h0A, 8'h14, 8'h08, 8'h09, 8'h20, 8'h04,   // post dividers
        8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h1A,   // outputs on, non-inverted
        8'h00, 8'h1A};         // spread settings, byte count
endpackage

// >>> verif/psc_smbus_host.sv
// psc_smbus_host: behavioural SMBus master driving the clock line and open-drain data
`timescale 1ns/1ps
module psc_smbus_host (
    // bench clock, all line changes land on its falling edge
    input wire logic clock,
    // resolved data wire
    input wire logic sdaWire,
    // host side of the bus
    output logic sclOut,
    output logic sdaRel
);
    // both lines start released, so the pull-ups hold them high
    initial begin
        sclOut = 1'b1;
        sdaRel = 1'b1;
    end

    // wait n falling edges
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one bit: data moves only with scl low, sampled late in the high phase
    task automatic bitx(input logic b, output logic s);
        sdaRel = b;
        idle(3);
        sclOut = 1'b1;
        idle(6);
        s = sdaWire;
        sclOut = 1'b0;
        idle(3);
    endtask

    // start or repeated start: data falls while scl is high
    task automatic start();
        sdaRel = 1'b1;
        idle(3);
        sclOut = 1'b1;
        idle(5);
        sdaRel = 1'b0;
        idle(5);
        sclOut = 1'b0;
        idle(3);
    endtask

    // stop: data rises while scl is high
    task automatic stop();
        sdaRel = 1'b0;
        idle(3);
        sclOut = 1'b1;
        idle(5);
        sdaRel = 1'b1;
        idle(5);
    endtask

    // eight bits msb first, then the ninth bit: last=1 releases (write ack or read nack)
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], s);
            rx[i] = s;
        end
        bitx(last, ack);
    endtask
endmodule // psc_smbus_host

// >>> verif/tb.sv
// tb: self-checking bench for the config logic, traffic through the SMBus host model
`timescale 1ns/1ps
module tb;
    // identity values given to the device, arbitrary
    localparam logic [3:0] VID = 4'h5;
    localparam logic [3:0] REV = 4'h2;
    // clock, reset and control pins
    logic clock, rst, controlPinZero, controlPinOne;
    // bus wires: data is wired-and of both open-drain drivers
    logic sclOut, sdaRel, sdaOut, sdaOutEnN;
    wire logic sdaWire = sdaRel & (sdaOutEnN | sdaOut);
    // design outputs
    logic [8:0] refDiv1, refDiv2, refDiv3;
    logic [11:0] fbDiv1, fbDiv2, fbDiv3;
    logic [2:0] pllBypass, vcoRange;
    logic [17:0] chanSource;
    logic pllPowerDown, inputStagePowerDown, outputsHiZ, outputsForcedLow;
    logic dividerBypass, inputSelect, spreadPowerDown;
    logic [1:0] inputSource;
    int nErrors = 0;
    int testsRun = 0;
    logic [7:0] d, c;
    logic a;
    // bytes 1..6 of the block write; reference ratio never above feedback ratio
    logic [7:0] blk [6] = '{8'hFF, 8'hFF, 8'hAF, 8'hFF, 8'hFF, 8'h5F};

    psc_config #(.VENDOR_ID(VID), .REVISION(REV)) psc_config_inst (
        .clock(clock), .rst(rst), .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOutEnN(sdaOutEnN), .controlPinZero(controlPinZero), .controlPinOne(controlPinOne),
        .refDiv1(refDiv1), .refDiv2(refDiv2), .refDiv3(refDiv3), .fbDiv1(fbDiv1),
        .fbDiv2(fbDiv2), .fbDiv3(fbDiv3), .pllBypass(pllBypass), .vcoRange(vcoRange),
        .chanSource(chanSource), .pllPowerDown(pllPowerDown),
        .inputStagePowerDown(inputStagePowerDown), .outputsHiZ(outputsHiZ),
        .outputsForcedLow(outputsForcedLow), .dividerBypass(dividerBypass),
        .inputSelect(inputSelect), .inputSource(inputSource),
        .spreadPowerDown(spreadPowerDown));
    psc_smbus_host psc_smbus_host_inst (.clock(clock), .sdaWire(sdaWire), .sclOut(sclOut),
        .sdaRel(sdaRel));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // verdict and end of run
    task automatic summarize();
        if (nErrors == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one comparison, four-state so an unknown never matches
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // byte write: address, command, data, each byte must be acked
    task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
        logic a0, a1, a2;
        psc_smbus_host_inst.start();
        psc_smbus_host_inst.xfer(8'hAA, 1'b1, d, a0);
        psc_smbus_host_inst.xfer(cmd, 1'b1, d, a1);
        psc_smbus_host_inst.xfer(dat, 1'b1, d, a2);
        psc_smbus_host_inst.stop();
        chk("writeAck", 0, a0 | a1 | a2);
    endtask

    // byte read, or block read when blk is set (count byte first)
    task automatic rd(input logic [7:0] cmd, input logic blk, output logic [7:0] q,
                      output logic [7:0] cnt);
        logic ak;
        psc_smbus_host_inst.start();
        psc_smbus_host_inst.xfer(8'hAA, 1'b1, q, ak);
        psc_smbus_host_inst.xfer(cmd, 1'b1, q, ak);
        psc_smbus_host_inst.start();
        psc_smbus_host_inst.xfer(8'hAB, 1'b1, q, ak);
        if (blk) psc_smbus_host_inst.xfer(8'hFF, 1'b0, cnt, ak);
        psc_smbus_host_inst.xfer(8'hFF, 1'b1, q, ak);
        psc_smbus_host_inst.stop();
    endtask

    // factory state, with both control pins high
    task automatic chkDefaults();
        chk("refDiv1", 1, refDiv1);
        chk("refDiv2", 27, refDiv2);
        chk("refDiv3", 375, refDiv3);
        chk("fbDiv1", 8, fbDiv1);
        chk("fbDiv2", 250, fbDiv2);
        chk("fbDiv3", 3136, fbDiv3);
        chk("pllBypass", 0, pllBypass);
        chk("vcoRange", 3'b111, vcoRange);
        chk("chanSource", {3'd1, 3'd1, 3'd1, 3'd1, 3'd4, 3'd2}, chanSource);
        chk("outputsOn", 0, {outputsHiZ, outputsForcedLow, pllPowerDown});
        chk("spreadPd", 1, spreadPowerDown);
        chk("inputSource", 0, inputSource);
        chk("sdaOut", 0, sdaOut);
    endtask

    // hang guard: the sequence needs roughly 11k cycles
    initial begin
        repeat (60000) @(posedge clock);
        nErrors++;
        summarize();
    end

    // main sequence, inputs change on the falling edge
    initial begin
        rst = 1'b1;
        controlPinZero = 1'b1;
        controlPinOne = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chkDefaults();
        rd(8'h13, 1'b0, d, c);
        chk("outEnable", 2'b01, {d[6], d[3]});
        rd(8'h00, 1'b0, d, c);
        chk("idByte", {REV, VID}, d);
        wr(8'h00, 8'hFF);
        rd(8'h00, 1'b0, d, c);
        chk("idKept", {REV, VID}, d);
        rd(8'h80, 1'b1, d, c);
        chk("blkCount", 8'h1A, c);
        chk("blkId", 8'h00, d);
        rd(8'h1B, 1'b0, d, c);
        chk("unmapped", 8'h00, d);
        // block write of bytes 1..6 with boundary ratios
        psc_smbus_host_inst.start();
        psc_smbus_host_inst.xfer(8'hAA, 1'b1, d, a);
        psc_smbus_host_inst.xfer(8'h81, 1'b1, d, a);
        psc_smbus_host_inst.xfer(8'h06, 1'b1, d, a);
        foreach (blk[i]) psc_smbus_host_inst.xfer(blk[i], 1'b1, d, a);
        psc_smbus_host_inst.stop();
        chk("refDiv1Max", 9'h0FF, refDiv1);
        chk("refDiv2Max", 9'h1FF, refDiv2);
        chk("fbDiv1Max", 12'hFFF, fbDiv1);
        chk("fbDiv2Max", 12'hFFF, fbDiv2);
        chk("pllBypassSet", 3'b101, pllBypass);
        chk("vcoRangeSet", 3'b010, vcoRange);
        rd(8'h03, 1'b0, d, c);
        chk("byte3Back", 8'hAF, d);
        wr(8'h01, 8'h00);
        chk("refDivZero", 1, refDiv1);
        // every source code on channel two
        for (int k = 0; k < 8; k++) begin
            wr(8'h0B, {5'b00001, k[2:0]});
            chk("p2Source", k, chanSource[8:6]);
        end
        // pin zero low with function 00, pin one low asks for forced low
        controlPinZero = 1'b0;
        controlPinOne = 1'b0;
        repeat (3) @(negedge clock);
        chk("powerDown", 3'b111, {pllPowerDown, inputStagePowerDown, outputsHiZ});
        chk("pdBeatsLow", 0, outputsForcedLow);
        controlPinOne = 1'b1;
        wr(8'h0A, 8'h81);
        chk("testBypass", 3'b110, {dividerBypass, pllPowerDown, outputsHiZ});
        wr(8'h0B, 8'h49);
        chk("inSrcCmos", 2'b01, inputSource);
        wr(8'h0A, 8'h82);
        chk("pinSelLow", 2'b00, {inputSelect, pllPowerDown});
        controlPinZero = 1'b1;
        repeat (3) @(negedge clock);
        chk("pinSelHigh", 1, inputSelect);
        wr(8'h0B, 8'h89);
        chk("inSrcDiff", 2'b10, inputSource);
        chk("pinSelDiff", 0, inputSelect);
        rd(8'h0A, 1'b0, d, c);
        chk("byte10Back", 8'h82, d);
        // pin one alone, no power-down: forced low, then high impedance
        controlPinOne = 1'b0;
        repeat (3) @(negedge clock);
        chk("pin1Low", 2'b01, {outputsHiZ, outputsForcedLow});
        wr(8'h0A, 8'h86);
        chk("pin1HiZ", 2'b10, {outputsHiZ, outputsForcedLow});
        controlPinOne = 1'b1;
        wr(8'h19, 8'h10);
        chk("spreadOn", 0, spreadPowerDown);
        // power-down register bit with both pins high
        wr(8'h0C, 8'h49);
        chk("pdBit", 3'b111, {pllPowerDown, inputStagePowerDown, outputsHiZ});
        // foreign address is not acknowledged
        psc_smbus_host_inst.start();
        psc_smbus_host_inst.xfer(8'hA8, 1'b1, d, a);
        psc_smbus_host_inst.stop();
        chk("otherAddr", 1, a);
        // second reset brings the factory state back
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chkDefaults();
        summarize();
    end
endmodule // tb
